/* sysint_pkg.sv */
// shared constants for the system integration unit
package sysint_pkg;
    localparam logic [2:0] ADDR_PEND_MID    = 3'h0;
    localparam logic [2:0] ADDR_PEND_TOP    = 3'h1;
    localparam logic [2:0] ADDR_BREAK_WAKE  = 3'h2;
    localparam logic [2:0] ADDR_RESET_CAUSE = 3'h3;
    localparam logic [2:0] ADDR_BREAK_CTRL  = 3'h4;
    localparam logic [2:0] ADDR_OPTIONS     = 3'h5;
    localparam int BREAK_WAKE_BIT = 1;
    localparam int CAUSE_LOW_VOLT   = 1;
    localparam int CAUSE_MOD        = 2;
    localparam int CAUSE_BAD_FETCH  = 3;
    localparam int CAUSE_BAD_OPCODE = 4;
    localparam int CAUSE_WATCHDOG   = 5;
    localparam int CAUSE_PIN  = 6;
    localparam int CAUSE_POR  = 7;
    localparam int OPT_SHORT_REC = 0;
    localparam int OPT_WDOG_DIS  = 1;
    localparam logic [7:0] RESET_CAUSE_POR_VALUE = 8'h80;
    localparam int RECOVERY_LONG  = 4096;
    localparam int RECOVERY_SHORT = 32;
    localparam logic [15:0] VECTOR_SOFTWARE_TRAP = 16'hFFFC;
    localparam logic [15:0] VECTOR_RESET         = 16'hFFFE;
    localparam logic [7:0]  ERASED_BYTE          = 8'hFF;
endpackage

/* sysint_recovery_counter.sv */
// stop recovery counter advanced on falling edges of the slow clock
`timescale 1ns/100ps
`default_nettype none
module sysint_recovery_counter #(
    parameter int LONG_COUNT  = sysint_pkg::RECOVERY_LONG,
    parameter int SHORT_COUNT = sysint_pkg::RECOVERY_SHORT
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic hold,
    input  wire logic slow_fall,
    input  wire logic short_sel,
    output logic      done
);
    typedef struct packed {
        logic [12:0] count;
        logic        done;
    } state_s;
    state_s s_q;
    state_s s_d;
    logic [12:0] limit;

    always_comb begin
        limit = short_sel ? 13'(SHORT_COUNT) : 13'(LONG_COUNT);
        s_d = s_q;
        if (hold) begin
            s_d.count = 13'h0000;
            s_d.done  = 1'b0;
        end else if (slow_fall && !s_q.done) begin
            s_d.count = s_q.count + 13'h0001;
            if (s_q.count + 13'h0001 >= limit) begin
                s_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;

    a_done_after_count: assert property (@(posedge clock) disable iff (rst)
        $rose(s_q.done) |-> ($past(s_q.count) + 13'h0001 >= limit))
        else $error("recovery ended early");
    a_hold_clears: assert property (@(posedge clock) disable iff (rst)
        hold |=> (s_q.count == 13'h0000 && !s_q.done))
        else $error("recovery counter not held");
endmodule
`default_nettype wire

/* sysint_lowpower_break_reset.sv */
// system integration unit: pending flags, reset cause, break and low power control
//
// Behaviour
// - pending flag bit reads one while its source requests, zero otherwise.
// - any reset source wins over all interrupts, no arbitration among resets.
// - break request forces a fetch of the software trap vector.
// - with clear enable low, peripheral flag clears are blocked in break.
// - with clear enable high, clears work in break and stay cleared.
// - two-step clears stay blocked in break; second step after break works.
// - wait or stop clears the global interrupt mask and stops the CPU clock.
// - wait mode gates CPU clocks, peripheral clocks keep running.
// - enabled interrupt, reset or break ends wait; stacking one cycle later.
// - watchdog enabled and running in wait when its disable option is zero.
// - stop resets recovery counter and disables all system clocks.
// - stop ends on interrupt, reset or break; interrupt waits out recovery.
// - recovery lasts 4096 slow clocks, or 32 with short recovery set.
// - recovery counter held cleared from stop until recovery begins.
// - break in wait or stop sets break wake flag; cleared by zero write, reset.
// - reading the reset cause register clears all its flags.
// - power-on reset sets its flag and clears all others.
// - separate cause flags: pin, watchdog, bad opcode, bad fetch, low voltage.
// - monitor entry flag set when erased reset vector and interrupt pin high.
// - recovery counter advances on falling slow clock edge.
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module sysint_lowpower_break_reset (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        por_event,
    input  wire logic        pin_reset_n,
    input  wire logic        watchdog_timeout,
    input  wire logic        bad_opcode,
    input  wire logic        bad_fetch_address,
    input  wire logic        low_voltage,
    input  wire logic        monitor_entry,
    input  wire logic        internal_slow_clock,
    input  wire logic [5:0]  pend_mid_src,
    input  wire logic        converter_done_pending,
    input  wire logic        irq_enabled_pending,
    input  wire logic        break_request,
    input  wire logic        wait_exec,
    input  wire logic        stop_exec,
    input  wire logic [2:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr_strobe,
    input  wire logic        rd_strobe,
    output logic [7:0]       rdata,
    output logic             system_reset,
    output logic             force_trap_fetch,
    output logic [15:0]      vector_addr,
    output logic             clear_global_mask,
    output logic             cpu_clock_enable,
    output logic             periph_clock_enable,
    output logic             bus_clock_source,
    output logic             stack_start,
    output logic             watchdog_enable,
    output logic             flag_clear_allow,
    output logic             break_active
);
    typedef enum logic [1:0] {RUN, WAITING, STOPPED, RECOVER} mode_e;

    typedef struct packed {
        mode_e      mode;
        logic [1:0] slow_sync;
        logic       slow_prev;
        logic [1:0] pin_sync;
        logic [7:0] pend_mid;
        logic [7:0] pend_top;
        logic       break_wake;
        logic [7:0] cause;
        logic       clear_enable;
        logic [1:0] options;
        logic       in_break;
        logic       rec_irq;
        logic [7:0] rdata;
        logic       reset_out;
        logic       trap;
        logic [15:0] vector;
        logic       clr_mask;
        logic       cpu_en;
        logic       per_en;
        logic       bus_en;
        logic       stack;
        logic       wdog_en;
        logic       clr_allow;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic   slow_fall;
    logic   rec_hold;
    logic   rec_done;
    logic   any_reset;
    logic   low_power;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sysint_recovery_counter u_recovery (
        .clock     (clock),
        .rst       (rst),
        .hold      (rec_hold),
        .slow_fall (slow_fall),
        .short_sel (s_q.options[sysint_pkg::OPT_SHORT_REC]),
        .done      (rec_done)
    );

    always_comb begin
        slow_fall = s_q.slow_prev && !s_q.slow_sync[1];
        rec_hold  = (s_q.mode != RECOVER);
        any_reset = por_event || !s_q.pin_sync[1] || watchdog_timeout || bad_opcode
                    || bad_fetch_address || low_voltage || monitor_entry;
        low_power = (s_q.mode != RUN);
        s_d = s_q;
        s_d.slow_sync = {s_q.slow_sync[0], internal_slow_clock};
        s_d.slow_prev = s_q.slow_sync[1];
        s_d.pin_sync  = {s_q.pin_sync[0], pin_reset_n};
        s_d.pend_mid  = {pend_mid_src[5:2], 2'b00, pend_mid_src[1:0]};
        s_d.pend_top  = {7'h00, converter_done_pending};
        s_d.trap      = 1'b0;
        s_d.stack     = 1'b0;
        s_d.clr_mask  = 1'b0;
        s_d.reset_out = 1'b0;
        s_d.rdata     = 8'h00;

        if (rd_strobe) begin
            if (addr == sysint_pkg::ADDR_PEND_MID) begin
                s_d.rdata = s_q.pend_mid;
            end else if (addr == sysint_pkg::ADDR_PEND_TOP) begin
                s_d.rdata = s_q.pend_top;
            end else if (addr == sysint_pkg::ADDR_BREAK_WAKE) begin
                s_d.rdata = 8'(s_q.break_wake) << sysint_pkg::BREAK_WAKE_BIT;
            end else if (addr == sysint_pkg::ADDR_RESET_CAUSE) begin
                s_d.rdata = s_q.cause;
                s_d.cause = 8'h00;
            end else if (addr == sysint_pkg::ADDR_BREAK_CTRL) begin
                s_d.rdata = {s_q.clear_enable, 7'h00};
            end else if (addr == sysint_pkg::ADDR_OPTIONS) begin
                s_d.rdata = {6'h00, s_q.options};
            end
        end
        if (wr_strobe) begin
            // pending registers ignore writes
            if (addr == sysint_pkg::ADDR_BREAK_WAKE) begin
                if (!wdata[sysint_pkg::BREAK_WAKE_BIT]) begin
                    s_d.break_wake = 1'b0;
                end
            end else if (addr == sysint_pkg::ADDR_BREAK_CTRL) begin
                s_d.clear_enable = wdata[7];
            end else if (addr == sysint_pkg::ADDR_OPTIONS) begin
                s_d.options = wdata[1:0];
            end
        end

        // causes latch after a read clear so a new reset is never lost
        if (!s_q.pin_sync[1]) s_d.cause[sysint_pkg::CAUSE_PIN] = 1'b1;
        if (watchdog_timeout) s_d.cause[sysint_pkg::CAUSE_WATCHDOG] = 1'b1;
        if (bad_opcode) s_d.cause[sysint_pkg::CAUSE_BAD_OPCODE] = 1'b1;
        if (bad_fetch_address) s_d.cause[sysint_pkg::CAUSE_BAD_FETCH] = 1'b1;
        if (low_voltage) s_d.cause[sysint_pkg::CAUSE_LOW_VOLT] = 1'b1;
        if (monitor_entry) s_d.cause[sysint_pkg::CAUSE_MOD] = 1'b1;
        if (por_event) s_d.cause = sysint_pkg::RESET_CAUSE_POR_VALUE;

        // break protection: peripherals see allow low during break unless enabled
        if (break_request) s_d.in_break = 1'b1;
        else if (!break_request && s_q.in_break && !low_power) s_d.in_break = 1'b0;
        // next enable value, so a cleared enable blocks in the same cycle
        s_d.clr_allow = !s_d.in_break || s_d.clear_enable;

        case (s_q.mode)
            RUN: begin
                if (wait_exec) begin
                    s_d.mode = WAITING;
                    s_d.clr_mask = 1'b1;
                end else if (stop_exec) begin
                    s_d.mode = STOPPED;
                    s_d.clr_mask = 1'b1;
                end
            end
            WAITING: begin
                if (break_request) begin
                    s_d.break_wake = 1'b1;
                    s_d.mode = RUN;
                end else if (irq_enabled_pending) begin
                    s_d.mode = RUN;
                    s_d.stack = 1'b1;
                end
            end
            STOPPED: begin
                if (break_request || irq_enabled_pending) begin
                    s_d.mode = RECOVER;
                    s_d.rec_irq = irq_enabled_pending && !break_request;
                    if (break_request) s_d.break_wake = 1'b1;
                end
            end
            RECOVER: begin
                if (rec_done) begin
                    s_d.mode = RUN;
                    s_d.stack = s_q.rec_irq;
                end
            end
            default: s_d.mode = RUN;
        endcase

        if (break_request && !any_reset) begin
            s_d.trap = 1'b1;
            s_d.vector = sysint_pkg::VECTOR_SOFTWARE_TRAP;
        end
        if (any_reset) begin
            s_d.reset_out = 1'b1;
            s_d.trap = 1'b0;
            s_d.stack = 1'b0;
            s_d.vector = sysint_pkg::VECTOR_RESET;
            // reset leaves wait and stop, break wake flag cleared
            s_d.mode = RUN;
            s_d.break_wake = 1'b0;
        end

        s_d.cpu_en  = (s_d.mode == RUN);
        s_d.per_en  = (s_d.mode == RUN) || (s_d.mode == WAITING);
        s_d.bus_en  = (s_d.mode == RUN) || (s_d.mode == WAITING);
        s_d.wdog_en = !s_q.options[sysint_pkg::OPT_WDOG_DIS];
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.pin_sync  <= 2'b11;
            s_q.cause     <= sysint_pkg::RESET_CAUSE_POR_VALUE;
            s_q.cpu_en    <= 1'b1;
            s_q.per_en    <= 1'b1;
            s_q.bus_en    <= 1'b1;
            s_q.wdog_en   <= 1'b1;
            s_q.clr_allow <= 1'b1;
            s_q.vector    <= sysint_pkg::VECTOR_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata               = s_q.rdata;
    assign system_reset        = s_q.reset_out;
    assign force_trap_fetch    = s_q.trap;
    assign vector_addr         = s_q.vector;
    assign clear_global_mask   = s_q.clr_mask;
    assign cpu_clock_enable    = s_q.cpu_en;
    assign periph_clock_enable = s_q.per_en;
    assign bus_clock_source    = s_q.bus_en;
    assign stack_start         = s_q.stack;
    assign watchdog_enable     = s_q.wdog_en;
    assign flag_clear_allow    = s_q.clr_allow;
    assign break_active        = s_q.in_break;

    sequence enter_low_power;
        s_q.mode == RUN && (wait_exec || stop_exec) && !any_reset;
    endsequence

    a_mask_on_entry: assert property (@(posedge clock) disable iff (rst)
        enter_low_power |=> (clear_global_mask && !cpu_clock_enable))
        else $error("low power entry without mask clear");
    a_pending_zero: assert property (@(posedge clock) disable iff (rst)
        (s_q.pend_mid[3:2] == 2'b00) && (s_q.pend_top[7:1] == 7'h00))
        else $error("unused pending bit set");
    a_pending_track: assert property (@(posedge clock) disable iff (rst)
        ##1 s_q.pend_top[0] == $past(converter_done_pending))
        else $error("pending flag mismatch");
    a_reset_priority: assert property (@(posedge clock) disable iff (rst)
        any_reset |=> (system_reset && !force_trap_fetch && !stack_start))
        else $error("reset lost priority");
    a_break_trap: assert property (@(posedge clock) disable iff (rst)
        (break_request && !any_reset) |=> (force_trap_fetch && vector_addr == sysint_pkg::VECTOR_SOFTWARE_TRAP))
        else $error("break did not force trap");
    a_break_protect: assert property (@(posedge clock) disable iff (rst)
        (break_active && !s_q.clear_enable) |-> !flag_clear_allow)
        else $error("flag clear allowed in break");
    a_wait_clocks: assert property (@(posedge clock) disable iff (rst)
        (s_q.mode == WAITING) |=> ##0 (!cpu_clock_enable || s_q.mode == RUN) && (periph_clock_enable || s_q.mode != WAITING))
        else $error("wait clock gating wrong");
    a_wait_stack: assert property (@(posedge clock) disable iff (rst)
        (s_q.mode == WAITING && irq_enabled_pending && !break_request && !any_reset) |=> stack_start)
        else $error("wait wake stacking late");
    a_stop_clocks: assert property (@(posedge clock) disable iff (rst)
        (s_q.mode == STOPPED) |-> (!bus_clock_source && !periph_clock_enable))
        else $error("clocks running in stop");
    a_break_wake: assert property (@(posedge clock) disable iff (rst)
        (low_power && s_q.mode != RECOVER && break_request && !any_reset) |=> s_q.break_wake)
        else $error("break wake flag not set");
    a_cause_read: assert property (@(posedge clock) disable iff (rst)
        (rd_strobe && addr == sysint_pkg::ADDR_RESET_CAUSE && !any_reset) |=> s_q.cause == 8'h00)
        else $error("reset cause not cleared by read");
    a_por_cause: assert property (@(posedge clock) disable iff (rst)
        por_event |=> s_q.cause == sysint_pkg::RESET_CAUSE_POR_VALUE)
        else $error("power-on cause wrong");
    a_wdog_enable: assert property (@(posedge clock) disable iff (rst)
        !s_q.options[sysint_pkg::OPT_WDOG_DIS] |=> watchdog_enable)
        else $error("watchdog not enabled");

    a_clear_enabled: assert property (
        (break_active && s_q.clear_enable) |-> flag_clear_allow)
        else $error("clear blocked although enabled");
    a_break_state: assert property (
        break_request |=> break_active)
        else $error("break state not entered");
    a_wait_gating: assert property (
        (s_q.mode == WAITING) |-> (periph_clock_enable && !cpu_clock_enable))
        else $error("wait gating wrong");
    a_wait_break_exit: assert property (
        (s_q.mode == WAITING && break_request) |=> (s_q.mode == RUN))
        else $error("break did not end wait");
    a_mask_pulse: assert property (
        clear_global_mask |=> !clear_global_mask)
        else $error("mask clear pulse too long");
    a_reset_exit: assert property (
        any_reset |=> (s_q.mode == RUN && !s_q.break_wake && cpu_clock_enable))
        else $error("reset did not end low power");

    sequence stop_irq_wake;
        s_q.mode == STOPPED && irq_enabled_pending && !break_request && !any_reset;
    endsequence

    a_stop_no_early: assert property (
        stop_irq_wake |=> (s_q.mode == RECOVER && !stack_start))
        else $error("stacking before recovery");
    a_recover_held: assert property (
        (s_q.mode == STOPPED) |=> !rec_done)
        else $error("recovery counter ran in stop");
    a_stack_after_rec: assert property (
        (s_q.mode == RECOVER && rec_done && s_q.rec_irq && !any_reset) |=> stack_start)
        else $error("no stacking after recovery");

    // each cause latches one cycle after it is seen; power-on overrides all
    a_cause_pin: assert property (
        (!s_q.pin_sync[1] && !por_event) |=> s_q.cause[sysint_pkg::CAUSE_PIN])
        else $error("pin cause lost");
    a_cause_watchdog: assert property (
        (watchdog_timeout && !por_event) |=> s_q.cause[sysint_pkg::CAUSE_WATCHDOG])
        else $error("watchdog cause lost");
    a_cause_opcode: assert property (
        (bad_opcode && !por_event) |=> s_q.cause[sysint_pkg::CAUSE_BAD_OPCODE])
        else $error("opcode cause lost");
    a_cause_fetch: assert property (
        (bad_fetch_address && !por_event) |=> s_q.cause[sysint_pkg::CAUSE_BAD_FETCH])
        else $error("fetch cause lost");
    a_cause_low_volt: assert property (
        (low_voltage && !por_event) |=> s_q.cause[sysint_pkg::CAUSE_LOW_VOLT])
        else $error("low voltage cause lost");
    a_cause_monitor: assert property (
        (monitor_entry && !por_event) |=> s_q.cause[sysint_pkg::CAUSE_MOD])
        else $error("monitor cause lost");
endmodule
`default_nettype wire

/* cpu_periph_model.sv */
// far-side model: free-running slow oscillator that feeds the integration unit
`timescale 1ns/100ps
`default_nettype none
module cpu_periph_model #(
    parameter int HALF_CYCLES = 2
) (
    input  wire logic clock,
    output logic      internal_slow_clock
);
    int count;

    initial begin
        count = 0;
        internal_slow_clock = 1'b0;
    end

    // runs fast on purpose so the long recovery fits in a short run
    always @(posedge clock) begin
        if (count == HALF_CYCLES - 1) begin
            count <= 0;
            internal_slow_clock <= ~internal_slow_clock;
        end else begin
            count <= count + 1;
        end
    end
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the system integration unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        clock, rst, por_event, pin_reset_n, watchdog_timeout, bad_opcode;
    logic        bad_fetch_address, low_voltage, monitor_entry, internal_slow_clock;
    logic [5:0]  pend_mid_src;
    logic        converter_done_pending, irq_enabled_pending, break_request;
    logic        wait_exec, stop_exec, wr_strobe, rd_strobe;
    logic [2:0]  addr;
    logic [7:0]  wdata, rdata, got;
    logic        system_reset, force_trap_fetch, clear_global_mask, cpu_clock_enable;
    logic        periph_clock_enable, bus_clock_source, stack_start, watchdog_enable;
    logic        flag_clear_allow, break_active;
    logic [15:0] vector_addr;
    logic [7:0]  exp_q[$];
    logic        rd_seen;
    int          fail_count, num_checks, n, span;
    int          cause_bit[6];

    sysint_lowpower_break_reset dut (.clock(clock), .rst(rst), .por_event(por_event),
        .pin_reset_n(pin_reset_n), .watchdog_timeout(watchdog_timeout), .bad_opcode(bad_opcode),
        .bad_fetch_address(bad_fetch_address), .low_voltage(low_voltage), .monitor_entry(monitor_entry),
        .internal_slow_clock(internal_slow_clock), .pend_mid_src(pend_mid_src),
        .converter_done_pending(converter_done_pending), .irq_enabled_pending(irq_enabled_pending),
        .break_request(break_request), .wait_exec(wait_exec), .stop_exec(stop_exec), .addr(addr),
        .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
        .system_reset(system_reset), .force_trap_fetch(force_trap_fetch), .vector_addr(vector_addr),
        .clear_global_mask(clear_global_mask), .cpu_clock_enable(cpu_clock_enable),
        .periph_clock_enable(periph_clock_enable), .bus_clock_source(bus_clock_source),
        .stack_start(stack_start), .watchdog_enable(watchdog_enable),
        .flag_clear_allow(flag_clear_allow), .break_active(break_active));

    cpu_periph_model model (.clock(clock), .internal_slow_clock(internal_slow_clock));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_strobe <= 1'b1;
        @(posedge clock);
        wr_strobe <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clock);
        exp_q.push_back(e);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clock);
        rd_strobe <= 1'b0;
    endtask

    task automatic settle();
        repeat (3) @(negedge clock);
    endtask

    // one low-power instruction, then sampled after its outputs land
    task automatic lp_exec(input logic stop);
        @(posedge clock);
        if (stop) stop_exec <= 1'b1;
        else wait_exec <= 1'b1;
        @(posedge clock);
        stop_exec <= 1'b0;
        wait_exec <= 1'b0;
        @(negedge clock);
    endtask

    task automatic wait_stack(input int limit, output int cyc);
        cyc = 0;
        while (stack_start !== 1'b1 && cyc < limit) begin
            @(posedge clock);
            #1;
            cyc++;
        end
        if (cyc >= limit) fail_count++;
    endtask

    // break held with the cause: reset must still win
    task automatic fire_cause(input int k);
        @(posedge clock);
        case (k)
            0: watchdog_timeout <= 1'b1;
            1: bad_opcode <= 1'b1;
            2: bad_fetch_address <= 1'b1;
            3: low_voltage <= 1'b1;
            4: monitor_entry <= 1'b1;
            default: pin_reset_n <= 1'b0;
        endcase
        break_request <= 1'b1;
        repeat (5) @(posedge clock);
        @(negedge clock);
        chk(16'(system_reset), 16'h0001);
        chk(16'(force_trap_fetch), 16'h0000);
        chk(vector_addr, sysint_pkg::VECTOR_RESET);
        @(posedge clock);
        {watchdog_timeout, bad_opcode, bad_fetch_address, low_voltage, monitor_entry} <= 5'h00;
        pin_reset_n <= 1'b1;
        break_request <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    // read results land one cycle after the strobe and only there
    always @(posedge clock) rd_seen <= rd_strobe;
    always @(negedge clock) begin
        if (rd_seen && exp_q.size() > 0) begin
            chk(16'(rdata), 16'(exp_q.pop_front()));
        end
    end

    initial begin
        repeat (40000) @(posedge clock);
        fail_count++;
        close_out();
    end

    initial begin
        {rst, por_event, pin_reset_n} = 3'b101;
        {watchdog_timeout, bad_opcode, bad_fetch_address, low_voltage, monitor_entry} = 5'h00;
        {pend_mid_src, converter_done_pending, irq_enabled_pending, break_request} = 9'h000;
        {wait_exec, stop_exec, wr_strobe, rd_strobe} = 4'h0;
        addr = 3'h0;
        wdata = 8'h00;
        fail_count = 0;
        num_checks = 0;
        cause_bit = '{sysint_pkg::CAUSE_WATCHDOG, sysint_pkg::CAUSE_BAD_OPCODE, sysint_pkg::CAUSE_BAD_FETCH,
                      sysint_pkg::CAUSE_LOW_VOLT, sysint_pkg::CAUSE_MOD, sysint_pkg::CAUSE_PIN};
        void'($urandom(22));
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        rd(sysint_pkg::ADDR_RESET_CAUSE, sysint_pkg::RESET_CAUSE_POR_VALUE);
        rd(sysint_pkg::ADDR_RESET_CAUSE, 8'h00);
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            pend_mid_src <= 6'($urandom);
            converter_done_pending <= 1'($urandom);
            settle();
            rd(sysint_pkg::ADDR_PEND_MID, {pend_mid_src[5:2], 2'b00, pend_mid_src[1:0]});
            rd(sysint_pkg::ADDR_PEND_TOP, {7'h00, converter_done_pending});
            wr(sysint_pkg::ADDR_PEND_TOP, 8'hFF);
            rd(sysint_pkg::ADDR_PEND_TOP, {7'h00, converter_done_pending});
        end
        rd(3'h7, 8'h00);
        for (int k = 0; k < 6; k++) begin
            fire_cause(k);
            rd(sysint_pkg::ADDR_RESET_CAUSE, 8'h01 << cause_bit[k]);
        end
        fire_cause(3);
        @(posedge clock) por_event <= 1'b1;
        @(posedge clock) por_event <= 1'b0;
        repeat (3) @(posedge clock);
        rd(sysint_pkg::ADDR_RESET_CAUSE, sysint_pkg::RESET_CAUSE_POR_VALUE);
        lp_exec(1'b0);
        chk(16'(clear_global_mask), 16'h0001);
        chk(16'(cpu_clock_enable), 16'h0000);
        chk(16'(periph_clock_enable), 16'h0001);
        chk(16'(watchdog_enable), 16'h0001);
        @(posedge clock) break_request <= 1'b1;
        settle();
        chk(16'(force_trap_fetch), 16'h0001);
        chk(vector_addr, sysint_pkg::VECTOR_SOFTWARE_TRAP);
        chk(16'(flag_clear_allow), 16'h0000);
        chk(16'(break_active), 16'h0001);
        rd(sysint_pkg::ADDR_BREAK_WAKE, 8'h01 << sysint_pkg::BREAK_WAKE_BIT);
        wr(sysint_pkg::ADDR_BREAK_CTRL, 8'h80);
        settle();
        chk(16'(flag_clear_allow), 16'h0001);
        rd(sysint_pkg::ADDR_BREAK_CTRL, 8'h80);
        wr(sysint_pkg::ADDR_BREAK_CTRL, 8'h00);
        wr(sysint_pkg::ADDR_BREAK_WAKE, 8'h00);
        settle();
        chk(16'(flag_clear_allow), 16'h0000);
        rd(sysint_pkg::ADDR_BREAK_WAKE, 8'h00);
        @(posedge clock) break_request <= 1'b0;
        settle();
        chk(16'(flag_clear_allow), 16'h0001);
        chk(16'(cpu_clock_enable), 16'h0001);
        chk(16'(break_active), 16'h0000);
        lp_exec(1'b0);
        @(posedge clock) irq_enabled_pending <= 1'b1;
        wait_stack(5, n);
        chk(16'(n >= 1 && n <= 2), 16'h0001);
        @(posedge clock) irq_enabled_pending <= 1'b0;
        wr(sysint_pkg::ADDR_OPTIONS, 8'h02);
        settle();
        chk(16'(watchdog_enable), 16'h0000);
        for (int s = 0; s < 2; s++) begin
            // second pass keeps short recovery cleared, as crystal parts must
            wr(sysint_pkg::ADDR_OPTIONS, (s == 0) ? 8'h01 : 8'h00);
            span = ((s == 0) ? sysint_pkg::RECOVERY_SHORT : sysint_pkg::RECOVERY_LONG) * 4;
            lp_exec(1'b1);
            chk(16'(clear_global_mask), 16'h0001);
            chk(16'(bus_clock_source), 16'h0000);
            chk(16'(periph_clock_enable), 16'h0000);
            // a long idle stop shows the counter was held, not running
            repeat (200) @(posedge clock);
            irq_enabled_pending <= 1'b1;
            wait_stack(20000, n);
            chk(16'(n >= span - 8 && n <= span + 16), 16'h0001);
            @(posedge clock) irq_enabled_pending <= 1'b0;
            settle();
            chk(16'(bus_clock_source), 16'h0001);
        end
        close_out();
    end
endmodule
`default_nettype wire
